// *** logic/scc_clock_ctrl.sv ***
// System clock select and oscillator run control registers with glitch-free switching
//
// What this block does
// - Any reset clears the system clock control register to zero.
// - CPU select bit picks main clock (0) or subsystem clock (1) for CPU.
// - CPU status bit shows which source now drives the CPU clock.
// - Main select bit picks on-chip oscillator (0) or high-speed clock (1).
// - Main status bit shows the source now used as main clock.
// - Bits 7 and 5 of system clock control ignore software writes.
// - CPU clock change moves ordinary peripherals; special units keep own clocks.
// - Reset sets main and sub stop bits, clears on-chip stop bit.
// - Sub stop bit is reset only by power-on reset.
// - Main stop bit runs or stops the main oscillator or external input.
// - Sub stop bit runs or stops the sub oscillator or external input.
// - On-chip stop bit runs the on-chip oscillator at 0, halts at 1.
// - Setting main stop bit clears the stabilization counter status.
// - Main oscillator use waits for the selected stabilization time.
`timescale 1ns/100ps
`default_nettype none
module scc_clock_ctrl (
  // Clock and resets
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        por_n,
  // Memory access port, 1-bit ops use a one-hot mask
  input  wire logic [19:0] mem_addr,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_wmask,
  input  wire logic        mem_rd,
  output logic [7:0]       mem_rdata,
  // Settings from neighbouring clock registers
  input  wire logic [1:0]  main_pin_mode,
  input  wire logic [1:0]  sub_pin_mode,
  input  wire logic [2:0]  stabilization_time_select,
  // Main oscillator clock pin, sampled for the stabilization count
  input  wire logic        main_clk_pin,
  // Oscillator controls
  output logic             main_osc_run,
  output logic             sub_osc_run,
  output logic             onchip_osc_run,
  // Clock tree controls
  output logic             cpu_clk_sub,
  output logic             main_clk_hs,
  output logic             clk_switch_hold,
  // Stabilization status
  output logic [7:0]       stabilization_counter_status
);

  typedef struct packed {
    logic [7:0]            rdata;
    logic                  cpu_sel;
    logic                  cpu_stat;
    logic                  main_sel;
    logic                  main_stat;
    logic                  main_stop;
    logic                  sub_stop;
    logic                  onchip_stop;
    logic                  hold;
    scc_pkg::scc_sw_state_t sw;
  } scc_ctrl_st_t;

  scc_ctrl_st_t st_reg;
  scc_ctrl_st_t st_next;
  scc_ctrl_st_t st_sys_reset;

  logic       sys_resetn;
  logic       stab_done;
  logic [7:0] sys_clk_ctrl_rd;
  logic [7:0] osc_run_ctrl_rd;
  logic [7:0] wr_sys;
  logic [7:0] wr_osc;
  logic       main_path_on;
  logic       sub_path_on;
  logic       main_target_ok;
  logic       cpu_target_ok;

  assign sys_resetn = resetn && por_n;

  // Main and sub stop bits only matter when the pin is in oscillator or external clock mode
  assign main_path_on = main_pin_mode[scc_pkg::PIN_MODE_ACTIVE_BIT];
  assign sub_path_on  = sub_pin_mode[scc_pkg::PIN_MODE_ACTIVE_BIT];

  scc_stab_counter #(
    .CNT_W (scc_pkg::STAB_CNT_W)
  ) u_stab (
    .clk      (clk),
    .resetn   (sys_resetn),
    .clear    (st_reg.main_stop),
    .run      (main_path_on),
    .time_sel (stabilization_time_select),
    .osc_pin  (main_clk_pin),
    .status   (stabilization_counter_status),
    .done     (stab_done)
  );

  // Read views, reserved bits forced to zero
  always_comb begin
    sys_clk_ctrl_rd                           = 8'h00;
    sys_clk_ctrl_rd[scc_pkg::CPU_STAT_BIT]    = st_reg.cpu_stat;
    sys_clk_ctrl_rd[scc_pkg::CPU_SEL_BIT]     = st_reg.cpu_sel;
    sys_clk_ctrl_rd[scc_pkg::MAIN_STAT_BIT]   = st_reg.main_stat;
    sys_clk_ctrl_rd[scc_pkg::MAIN_SEL_BIT]    = st_reg.main_sel;
    osc_run_ctrl_rd                           = 8'h00;
    osc_run_ctrl_rd[scc_pkg::MAIN_STOP_BIT]   = st_reg.main_stop;
    osc_run_ctrl_rd[scc_pkg::SUB_STOP_BIT]    = st_reg.sub_stop;
    osc_run_ctrl_rd[scc_pkg::ONCHIP_STOP_BIT] = st_reg.onchip_stop;
  end

  // Merged write data: masked bits take new data, others keep their value
  assign wr_sys = (sys_clk_ctrl_rd & ~mem_wmask) | (mem_wdata & mem_wmask);
  assign wr_osc = (osc_run_ctrl_rd & ~mem_wmask) | (mem_wdata & mem_wmask);

  // Target clock must already be running before the tree is moved to it, except a CPU move back to main clock, which is never checked
  assign main_target_ok = st_reg.main_sel ? (stab_done && !st_reg.main_stop)
                                          : !st_reg.onchip_stop;
  assign cpu_target_ok  = st_reg.cpu_sel ? (sub_path_on && !st_reg.sub_stop)
                                         : 1'b1;

  // Reset image for a system reset: sub stop bit survives it
  always_comb begin
    st_sys_reset             = '0;
    st_sys_reset.main_stop   = scc_pkg::OSC_RUN_CTRL_RESET[scc_pkg::MAIN_STOP_BIT];
    st_sys_reset.onchip_stop = scc_pkg::OSC_RUN_CTRL_RESET[scc_pkg::ONCHIP_STOP_BIT];
    st_sys_reset.sub_stop    = st_reg.sub_stop;
    st_sys_reset.sw          = scc_pkg::SW_IDLE;
  end

  always_comb begin
    st_next       = st_reg;
    st_next.rdata = scc_pkg::READ_IDLE;

    // Register reads
    if (mem_rd) begin
      case (mem_addr)
        scc_pkg::SYS_CLK_CTRL_ADDR: st_next.rdata = sys_clk_ctrl_rd;
        scc_pkg::OSC_RUN_CTRL_ADDR: st_next.rdata = osc_run_ctrl_rd;
        scc_pkg::STAB_STATUS_ADDR:  st_next.rdata = stabilization_counter_status;
        default:                    st_next.rdata = scc_pkg::READ_IDLE;
      endcase
    end

    // Register writes; status bits and reserved bits are not writable
    if (mem_wr) begin
      case (mem_addr)
        scc_pkg::SYS_CLK_CTRL_ADDR: begin
          st_next.cpu_sel  = wr_sys[scc_pkg::CPU_SEL_BIT];
          st_next.main_sel = wr_sys[scc_pkg::MAIN_SEL_BIT];
        end
        scc_pkg::OSC_RUN_CTRL_ADDR: begin
          st_next.main_stop   = wr_osc[scc_pkg::MAIN_STOP_BIT];
          st_next.sub_stop    = wr_osc[scc_pkg::SUB_STOP_BIT];
          st_next.onchip_stop = wr_osc[scc_pkg::ONCHIP_STOP_BIT];
        end
        default: begin
        end
      endcase
    end

    // Switch sequencer: hold the tree, move the mux, then release.
    // One hold cycle each side keeps runt pulses off the CPU clock.
    case (st_reg.sw)
      scc_pkg::SW_IDLE: begin
        st_next.hold = 1'b0;
        if (st_reg.cpu_sel != st_reg.cpu_stat && cpu_target_ok) begin
          st_next.hold = 1'b1;
          st_next.sw   = scc_pkg::SW_HOLD_CPU;
        end else if (st_reg.main_sel != st_reg.main_stat && main_target_ok) begin
          st_next.hold = 1'b1;
          st_next.sw   = scc_pkg::SW_HOLD_MAIN;
        end
      end
      scc_pkg::SW_HOLD_CPU: begin
        // Flip toward the target checked on entry; a select rewritten mid-hold waits
        st_next.cpu_stat = !st_reg.cpu_stat;
        st_next.sw       = scc_pkg::SW_MOVE_CPU;
      end
      scc_pkg::SW_MOVE_CPU: begin
        st_next.hold = 1'b0;
        st_next.sw   = scc_pkg::SW_IDLE;
      end
      scc_pkg::SW_HOLD_MAIN: begin
        st_next.main_stat = !st_reg.main_stat;
        st_next.sw        = scc_pkg::SW_MOVE_MAIN;
      end
      scc_pkg::SW_MOVE_MAIN: begin
        st_next.hold = 1'b0;
        st_next.sw   = scc_pkg::SW_IDLE;
      end
      default: begin
        st_next.hold = 1'b0;
        st_next.sw   = scc_pkg::SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!por_n) begin
      st_reg          <= '0;
      st_reg.main_stop <= scc_pkg::OSC_RUN_CTRL_RESET[scc_pkg::MAIN_STOP_BIT];
      st_reg.sub_stop  <= scc_pkg::OSC_RUN_CTRL_RESET[scc_pkg::SUB_STOP_BIT];
      st_reg.sw        <= scc_pkg::SW_IDLE;
    end else if (!resetn) begin
      st_reg <= st_sys_reset;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign mem_rdata       = st_reg.rdata;
  assign main_osc_run    = main_path_on && !st_reg.main_stop;
  assign sub_osc_run     = sub_path_on && !st_reg.sub_stop;
  assign onchip_osc_run  = !st_reg.onchip_stop;
  assign cpu_clk_sub     = st_reg.cpu_stat;
  assign main_clk_hs     = st_reg.main_stat;
  assign clk_switch_hold = st_reg.hold;

endmodule : scc_clock_ctrl
`default_nettype wire

// *** logic/scc_stab_counter.sv ***
// Main oscillator stabilization counter with threshold status bits
`timescale 1ns/100ps
`default_nettype none
module scc_stab_counter #(
  parameter int CNT_W = scc_pkg::STAB_CNT_W
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Control
  input  wire logic       clear,
  input  wire logic       run,
  input  wire logic [2:0] time_sel,
  // Oscillator clock pin, asynchronous
  input  wire logic       osc_pin,
  // Status
  output logic [7:0]      status,
  output logic            done
);

  if (CNT_W < scc_pkg::STAB_CNT_W) begin : g_bad_cnt_w
    $error("scc_stab_counter: CNT_W too small for the longest time");
  end

  typedef struct packed {
    logic [1:0]       sync;
    logic             prev;
    logic [CNT_W-1:0] cnt;
    logic [7:0]       status;
  } scc_stab_st_t;

  scc_stab_st_t st_reg;
  scc_stab_st_t st_next;
  logic [7:0]   reached;
  logic [2:0]   sel_idx;

  // Status bit 7-i reports threshold i reached
  for (genvar i = 0; i < scc_pkg::STAB_BITS; i++) begin : g_thr
    assign reached[scc_pkg::STAB_BITS-1-i] =
      st_reg.cnt >= (CNT_W'(1) << scc_pkg::STAB_EXP[scc_pkg::STAB_BITS-1-i]);
  end

  // Selected threshold index counted from the shortest time
  assign sel_idx = time_sel;
  assign done    = reached[3'h7 - sel_idx];
  assign status  = st_reg.status;

  always_comb begin
    st_next        = st_reg;
    st_next.sync   = {st_reg.sync[0], osc_pin};
    st_next.prev   = st_reg.sync[1];
    // Counting halts at the selected time, so longer bits stay clear
    if (clear || !run) begin
      st_next.cnt    = '0;
      st_next.status = '0;
    end else begin
      if (st_reg.sync[1] && !st_reg.prev && !done) begin
        st_next.cnt = st_reg.cnt + CNT_W'(1);
      end
      st_next.status = reached;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : scc_stab_counter
`default_nettype wire

// *** pkg/scc_pkg.sv ***
// Package: register map, field positions, reset values and types of the clock select block
package scc_pkg;

  // Register byte addresses on the memory access port
  localparam logic [19:0] OSC_RUN_CTRL_ADDR = 20'hfffa1;
  localparam logic [19:0] STAB_STATUS_ADDR  = 20'hfffa2;
  localparam logic [19:0] SYS_CLK_CTRL_ADDR = 20'hfffa4;

  // Reset values
  localparam logic [7:0] SYS_CLK_CTRL_RESET = 8'h00;
  localparam logic [7:0] OSC_RUN_CTRL_RESET = 8'hc0;
  localparam logic [7:0] READ_IDLE          = 8'h00;

  // system_clock_control field positions
  localparam int CPU_STAT_BIT  = 7;
  localparam int CPU_SEL_BIT   = 6;
  localparam int MAIN_STAT_BIT = 5;
  localparam int MAIN_SEL_BIT  = 4;

  // oscillator_run_control field positions
  localparam int MAIN_STOP_BIT   = 7;
  localparam int SUB_STOP_BIT    = 6;
  localparam int ONCHIP_STOP_BIT = 0;

  // Pin operation mode: the oscillator/external select bit enables the clock path
  localparam int PIN_MODE_ACTIVE_BIT = 0;

  // Stabilization counter: one threshold exponent per status bit, status bit 7 first
  localparam int                STAB_CNT_W  = 19;
  localparam int                STAB_BITS   = 8;
  localparam logic [7:0][4:0]   STAB_EXP    = {5'h08, 5'h09, 5'h0a, 5'h0b,
                                               5'h0d, 5'h0f, 5'h11, 5'h12};
  localparam logic [2:0]        STAB_SEL_RESET = 3'h7;

  // Clock switch sequencer
  typedef enum logic [2:0] {
    SW_IDLE,
    SW_HOLD_CPU,
    SW_MOVE_CPU,
    SW_HOLD_MAIN,
    SW_MOVE_MAIN
  } scc_sw_state_t;

endpackage : scc_pkg

// *** verification/scc_clock_ctrl_asserts.sv ***
// Checker for the clock select and oscillator run control block
`timescale 1ns/100ps
`default_nettype none
module scc_clock_ctrl_asserts (
  // Clock and resets
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        por_n,
  // Register port
  input wire logic [19:0] mem_addr,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  mem_wmask,
  input wire logic        mem_rd,
  input wire logic [7:0]  mem_rdata,
  // Clock controls
  input wire logic [1:0]  main_pin_mode,
  input wire logic [1:0]  sub_pin_mode,
  input wire logic        main_osc_run,
  input wire logic        sub_osc_run,
  input wire logic        onchip_osc_run,
  input wire logic        cpu_clk_sub,
  input wire logic        main_clk_hs,
  input wire logic        clk_switch_hold,
  input wire logic [7:0]  stabilization_counter_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || !por_n);
  wire osc_wr = mem_wr && (mem_addr == scc_pkg::OSC_RUN_CTRL_ADDR);
  wire osc_rd = mem_rd && (mem_addr == scc_pkg::OSC_RUN_CTRL_ADDR);
  wire ctl_rd = mem_rd && (mem_addr == scc_pkg::SYS_CLK_CTRL_ADDR);
  chk_onchip_run: assert property (
    osc_wr && mem_wmask[0] |=> onchip_osc_run == !$past(mem_wdata[0])) else $error("onchip run");
  chk_main_run: assert property (
    osc_wr && mem_wmask[7] |=> main_osc_run == (!$past(mem_wdata[7]) && main_pin_mode[0]))
    else $error("main run");
  chk_sub_run: assert property (
    osc_wr && mem_wmask[6] |=> sub_osc_run == (!$past(mem_wdata[6]) && sub_pin_mode[0]))
    else $error("sub run");
  chk_ctl_readback: assert property (
    ctl_rd |=> mem_rdata[3:0] == 4'h0 && mem_rdata[7] == $past(cpu_clk_sub)
    && mem_rdata[5] == $past(main_clk_hs)) else $error("ctl readback");
  chk_osc_reserved: assert property (
    osc_rd |=> mem_rdata[5:1] == 5'h00) else $error("osc reserved bits");
  chk_status_in_hold: assert property (
    $changed(cpu_clk_sub) || $changed(main_clk_hs) |-> clk_switch_hold && $past(clk_switch_hold))
    else $error("status moved outside hold");
  chk_hold_length: assert property (
    $rose(clk_switch_hold) |-> clk_switch_hold [*2] ##1 !clk_switch_hold) else $error("hold length");
  chk_hold_moves: assert property (
    $rose(clk_switch_hold) |=> $changed(cpu_clk_sub) || $changed(main_clk_hs)) else $error("no move");
  chk_stop_clears: assert property (
    osc_wr && mem_wmask[7] && mem_wdata[7] |-> ##[1:2] stabilization_counter_status == 8'h00)
    else $error("stab status not cleared");
  chk_stab_first: assert property (
    $rose(main_clk_hs) |-> stabilization_counter_status[7]) else $error("hs before stable");
  cover property ($rose(cpu_clk_sub));
  cover property ($rose(main_clk_hs));
  cover property ($fell(main_clk_hs));
endmodule : scc_clock_ctrl_asserts
bind scc_clock_ctrl scc_clock_ctrl_asserts u_chk (.clk(clk), .resetn(resetn), .por_n(por_n),
  .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_wmask(mem_wmask),
  .mem_rd(mem_rd), .mem_rdata(mem_rdata), .main_pin_mode(main_pin_mode),
  .sub_pin_mode(sub_pin_mode), .main_osc_run(main_osc_run), .sub_osc_run(sub_osc_run),
  .onchip_osc_run(onchip_osc_run), .cpu_clk_sub(cpu_clk_sub), .main_clk_hs(main_clk_hs),
  .clk_switch_hold(clk_switch_hold), .stabilization_counter_status(stabilization_counter_status));
`default_nettype wire

// *** verification/scc_clock_ctrl_tb.sv ***
// Self-checking testbench for the clock select block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk, resetn, por_n, mem_wr, mem_rd, main_clk_pin, pin_run;
  logic [19:0] mem_addr;
  logic [7:0]  mem_wdata, mem_wmask, mem_rdata, stab;
  logic [1:0]  main_pin_mode, sub_pin_mode;
  logic [2:0]  stab_sel;
  logic        main_osc_run, sub_osc_run, onchip_osc_run, cpu_clk_sub, main_clk_hs, hold;
  int          mismatches = 0;
  int          n_checks = 0;
  localparam logic [19:0] OSC = scc_pkg::OSC_RUN_CTRL_ADDR;
  localparam logic [19:0] CTL = scc_pkg::SYS_CLK_CTRL_ADDR;
  scc_clock_ctrl u_dut (.clk(clk), .resetn(resetn), .por_n(por_n), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_wmask(mem_wmask), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .main_pin_mode(main_pin_mode), .sub_pin_mode(sub_pin_mode),
    .stabilization_time_select(stab_sel), .main_clk_pin(main_clk_pin), .main_osc_run(main_osc_run),
    .sub_osc_run(sub_osc_run), .onchip_osc_run(onchip_osc_run), .cpu_clk_sub(cpu_clk_sub),
    .main_clk_hs(main_clk_hs), .clk_switch_hold(hold), .stabilization_counter_status(stab));
  always #25 clk = !clk;
  // Pin clock at half the system rate keeps the stabilization count short
  always @(posedge clk) if (pin_run) main_clk_pin <= !main_clk_pin;
  task finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [19:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk) {mem_wr, mem_addr, mem_wdata, mem_wmask} <= {1'b1, a, d, m};
    @(posedge clk) mem_wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input string n, input logic [19:0] a, input logic [7:0] e);
    @(posedge clk) {mem_rd, mem_addr} <= {1'b1, a};
    @(posedge clk) mem_rd <= 1'b0;
    #1;
    chk(n, e, mem_rdata);
  endtask : rd
  // Waits on a status output; the switch has no fixed latency once the target must start
  task wt(input bit m, input logic v);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if ((m ? main_clk_hs : cpu_clk_sub) === v) break;
    end
    if (i == 3000) begin
      mismatches++;
      $display("mismatch status_wait expected %0b seen %0b", v, m ? main_clk_hs : cpu_clk_sub);
      finish_test();
    end
  endtask : wt
  task rst(input bit por);
    @(posedge clk) {por_n, resetn} <= por ? 2'b01 : 2'b10;
    repeat (2) @(posedge clk);
    {por_n, resetn} <= 2'b11;
    #1;
  endtask : rst
  task t_reset();
    rd("sys_ctl", CTL, 8'h00);
    rd("osc_run", OSC, 8'hc0);
    chk("onchip_run", 8'h01, {7'h0, onchip_osc_run});
    $display("test reset done");
  endtask : t_reset
  task t_readonly();
    wr(CTL, 8'ha0, 8'hff);
    rd("sys_ctl_ro", CTL, 8'h00);
    wr(OSC, 8'h3e, 8'hff);
    rd("osc_rsvd", OSC, 8'h00);
    wr(OSC, 8'hc0, 8'hff);
    wr(20'hfffa3, 8'hff, 8'hff);
    rd("unmapped", 20'hfffa3, 8'h00);
    rd("osc_kept", OSC, 8'hc0);
    $display("test readonly done");
  endtask : t_readonly
  task t_sub();
    wr(CTL, 8'h40, 8'hff);
    repeat (10) @(posedge clk);
    chk("cpu_waits", 8'h00, {7'h0, cpu_clk_sub});
    chk("no_hold", 8'h00, {7'h0, hold});
    @(posedge clk) sub_pin_mode <= 2'h1;
    wr(OSC, 8'h00, 8'h40);
    rd("osc_bit_op", OSC, 8'h80);
    chk("sub_run", 8'h01, {7'h0, sub_osc_run});
    repeat (8) @(posedge clk);
    wt(1'b0, 1'b1);
    rd("sys_ctl_sub", CTL, 8'hc0);
    wr(CTL, 8'h00, 8'hff);
    wt(1'b0, 1'b0);
    chk("hold_in_switch", 8'h01, {7'h0, hold});
    rd("sys_ctl_main", CTL, 8'h00);
    chk("hold_released", 8'h00, {7'h0, hold});
    wr(OSC, 8'h40, 8'h40);
    chk("sub_stop", 8'h00, {7'h0, sub_osc_run});
    $display("test sub done");
  endtask : t_sub
  task t_main();
    @(posedge clk) {main_pin_mode, stab_sel} <= {2'h1, 3'h0};
    wr(OSC, 8'h00, 8'h80);
    chk("main_run", 8'h01, {7'h0, main_osc_run});
    wr(CTL, 8'h10, 8'hff);
    repeat (20) @(posedge clk);
    chk("hs_waits", 8'h00, {7'h0, main_clk_hs});
    pin_run <= 1'b1;
    wt(1'b1, 1'b1);
    rd("stab_done", 20'hfffa2, 8'h80);
    rd("sys_ctl_hs", CTL, 8'h30);
    wr(OSC, 8'h01, 8'h01);
    chk("onchip_stop", 8'h00, {7'h0, onchip_osc_run});
    wr(OSC, 8'h00, 8'h01);
    wr(CTL, 8'h00, 8'hff);
    wt(1'b1, 1'b0);
    wr(OSC, 8'h80, 8'h80);
    chk("main_stop", 8'h00, {7'h0, main_osc_run});
    rd("stab_clear", 20'hfffa2, 8'h00);
    // A longer time must keep the switch off past the shorter threshold
    @(posedge clk) stab_sel <= 3'h1;
    wr(OSC, 8'h00, 8'h80);
    wr(CTL, 8'h10, 8'hff);
    repeat (600) @(posedge clk);
    chk("hs_waits_long", 8'h00, {7'h0, main_clk_hs});
    rd("stab_mid", 20'hfffa2, 8'h80);
    wt(1'b1, 1'b1);
    rd("stab_long", 20'hfffa2, 8'hc0);
    wr(CTL, 8'h00, 8'hff);
    wt(1'b1, 1'b0);
    wr(OSC, 8'h80, 8'h80);
    pin_run <= 1'b0;
    $display("test main done");
  endtask : t_main
  task t_warm();
    wr(OSC, 8'h00, 8'h40);
    rst(1'b0);
    rd("osc_warm", OSC, 8'h80);
    rd("ctl_warm", CTL, 8'h00);
    rst(1'b1);
    rd("osc_por", OSC, 8'hc0);
    $display("test warm reset done");
  endtask : t_warm
  initial begin
    {clk, resetn, por_n, mem_wr, mem_rd, pin_run, main_clk_pin} = 7'h00;
    {mem_addr, mem_wdata, mem_wmask, main_pin_mode, sub_pin_mode} = '0;
    stab_sel = 3'h7;
    repeat (2) @(posedge clk);
    {por_n, resetn} <= 2'b11;
    t_reset();
    t_readonly();
    t_sub();
    t_main();
    t_warm();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
